/* File: pkg/port_a_pkg.sv */
// port_a_pkg: register map, field layout and reset values of the port
// assumes a byte-wide data-memory register bus with a small address field
package port_a_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;

  // register indices on the data-memory bus; no addresses are fixed
  // elsewhere, so these are local choices
  localparam logic [2:0] ADDR_DATA_LATCH = 3'h0;
  localparam logic [2:0] ADDR_DIRECTION  = 3'h1;
  localparam logic [2:0] ADDR_PULLUP     = 3'h2;
  localparam logic [2:0] ADDR_PULLDOWN   = 3'h3;
  localparam logic [2:0] ADDR_WAKEUP     = 3'h4;
  localparam logic [2:0] ADDR_FUNC_SEL   = 3'h5;

  // implemented bit positions
  localparam logic [7:0] PORT_MASK     = 8'he7;
  localparam logic [7:0] FUNC_SEL_MASK = 8'he2;

  // reset values
  localparam logic [7:0] RST_DATA_LATCH = 8'he7;
  localparam logic [7:0] RST_DIRECTION  = 8'he7;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // function select bit positions
  localparam int unsigned SELECT_BIT_SEVEN = 7;
  localparam int unsigned SELECT_BIT_SIX   = 6;
  localparam int unsigned SELECT_BIT_FIVE  = 5;
  localparam int unsigned SELECT_BIT_ONE   = 1;

  // pins affected by each select bit share its position
  localparam logic [7:0] SEL_ZERO = 8'h00;

  typedef enum logic [1:0] {
    pin_gpio,
    pin_analog,
    pin_timer_out,
    pin_amp_out
  } pin_func_t;

endpackage

/* File: rtl/port_a_gpio_with_wakeup.sv */
// port_a_gpio_with_wakeup: six-pin port with direction, latch, pulls,
// falling-edge wake and pin-shared function select
// assumes a single-cycle byte register bus with write and read strobes
`timescale 1ns/1ps
`default_nettype none
module port_a_gpio_with_wakeup
  import port_a_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              low_power,
  input  wire logic              timer_pwm_output,
  input  wire logic [7:0]        pin_in,
  output logic      [7:0]        pin_out,
  output logic      [7:0]        pin_oe_n,
  output logic      [7:0]        pullup_on,
  output logic      [7:0]        pulldown_on,
  output logic                   analog_input_zero,
  output logic                   analog_input_one,
  output logic                   amplifier_one_output,
  output logic                   timer_snapshot_input,
  output logic                   timer_clock_input,
  output logic                   wake_request
);

  logic [7:0]  port_data_latch;
  logic [7:0]  port_direction;
  logic [7:0]  port_pullup_enable;
  logic [7:0]  port_pulldown_enable;
  logic [7:0]  port_wakeup_enable;
  logic [7:0]  pin_function_select;
  logic [7:0]  port_read;
  logic [7:0]  next_rdata;
  logic [7:0]  wake_bits;
  logic [7:0]  analog_bits;
  logic [7:0]  amp_bits;
  pin_func_t   func [8];

  function automatic logic wr_hit(input logic [2:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  // writes keep only implemented positions
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_data_latch <= RST_DATA_LATCH;
    end else if (wr_hit(ADDR_DATA_LATCH)) begin
      port_data_latch <= reg_wdata & PORT_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_direction <= RST_DIRECTION;
    end else if (wr_hit(ADDR_DIRECTION)) begin
      port_direction <= reg_wdata & PORT_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_pullup_enable   <= RST_ZERO;
      port_pulldown_enable <= RST_ZERO;
      port_wakeup_enable   <= RST_ZERO;
    end else begin
      if (wr_hit(ADDR_PULLUP)) begin
        port_pullup_enable <= reg_wdata & PORT_MASK;
      end
      if (wr_hit(ADDR_PULLDOWN)) begin
        port_pulldown_enable <= reg_wdata & PORT_MASK;
      end
      if (wr_hit(ADDR_WAKEUP)) begin
        port_wakeup_enable <= reg_wdata & PORT_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_function_select <= RST_ZERO;
    end else if (wr_hit(ADDR_FUNC_SEL)) begin
      pin_function_select <= reg_wdata & FUNC_SEL_MASK;
    end
  end

  // per-pin function decode
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      func[i] = pin_gpio;
    end
    if (pin_function_select[SELECT_BIT_SEVEN]) begin
      func[SELECT_BIT_SEVEN] = pin_analog;
    end
    if (pin_function_select[SELECT_BIT_SIX]) begin
      func[SELECT_BIT_SIX] = pin_analog;
    end
    if (pin_function_select[SELECT_BIT_FIVE]) begin
      func[SELECT_BIT_FIVE] = pin_timer_out;
    end
    if (pin_function_select[SELECT_BIT_ONE]) begin
      func[SELECT_BIT_ONE] = pin_amp_out;
    end
  end

  // live level for inputs, latch for outputs; no input latch, so a
  // bit set/clear written back from this view copies input levels
  // into the latch, exactly as a read-modify-write does
  assign port_read = ((pin_in & port_direction)
                     | (port_data_latch & ~port_direction)) & PORT_MASK;

  always_comb begin
    next_rdata = RST_ZERO;
    if (reg_addr == ADDR_DATA_LATCH) begin
      next_rdata = port_read;
    end else if (reg_addr == ADDR_DIRECTION) begin
      next_rdata = port_direction;
    end else if (reg_addr == ADDR_PULLUP) begin
      next_rdata = port_pullup_enable;
    end else if (reg_addr == ADDR_PULLDOWN) begin
      next_rdata = port_pulldown_enable;
    end else if (reg_addr == ADDR_WAKEUP) begin
      next_rdata = port_wakeup_enable;
    end else if (reg_addr == ADDR_FUNC_SEL) begin
      next_rdata = pin_function_select;
    end
  end

  // data out from a flop: the read answers the cycle after reg_rd
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_pin
    if (PORT_MASK[g]) begin : g_impl
      port_pin_cell u_cell (
        .clk         (clk),
        .rst_n       (rst_n),
        .func        (func[g]),
        .dir_in      (port_direction[g]),
        .latch_val   (port_data_latch[g]),
        .pu_en       (port_pullup_enable[g]),
        .pd_en       (port_pulldown_enable[g]),
        .wu_en       (port_wakeup_enable[g]),
        .low_power   (low_power),
        .timer_out   (timer_pwm_output),
        .pin_in      (pin_in[g]),
        .pin_out     (pin_out[g]),
        .pin_oe_n    (pin_oe_n[g]),
        .pullup_on   (pullup_on[g]),
        .pulldown_on (pulldown_on[g]),
        .analog_sel  (analog_bits[g]),
        .amp_sel     (amp_bits[g]),
        .wake        (wake_bits[g])
      );
    end else begin : g_none
      assign pin_out[g]     = 1'b0;
      assign pin_oe_n[g]    = 1'b1;
      assign pullup_on[g]   = 1'b0;
      assign pulldown_on[g] = 1'b0;
      assign analog_bits[g] = 1'b0;
      assign amp_bits[g]    = 1'b0;
      assign wake_bits[g]   = 1'b0;
    end
  end

  assign analog_input_one     = analog_bits[SELECT_BIT_SEVEN];
  assign analog_input_zero    = analog_bits[SELECT_BIT_SIX];
  assign amplifier_one_output = amp_bits[SELECT_BIT_ONE];
  // peripheral inputs just follow the pad; direction is software's job
  assign timer_snapshot_input = pin_in[SELECT_BIT_ONE];
  assign timer_clock_input    = pin_in[SELECT_BIT_FIVE];
  assign wake_request         = |wake_bits;

endmodule // port_a_gpio_with_wakeup
`default_nettype wire

/* File: rtl/port_pin_cell.sv */
// port_pin_cell: one pad's output mux, pull gating and wake edge detect
// assumes pin input synchronous to clk; pad logic built outside
`timescale 1ns/1ps
`default_nettype none
module port_pin_cell
  import port_a_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire pin_func_t func,
  input  wire logic      dir_in,
  input  wire logic      latch_val,
  input  wire logic      pu_en,
  input  wire logic      pd_en,
  input  wire logic      wu_en,
  input  wire logic      low_power,
  input  wire logic      timer_out,
  input  wire logic      pin_in,
  output logic           pin_out,
  output logic           pin_oe_n,
  output logic           pullup_on,
  output logic           pulldown_on,
  output logic           analog_sel,
  output logic           amp_sel,
  output logic           wake
);

  logic gpio_input;
  logic pin_prev;

  assign gpio_input = (func == pin_gpio) && dir_in;

  // output pads: gpio output drives the latch right away
  always_comb begin
    pin_out  = latch_val;
    pin_oe_n = 1'b1;
    if (func == pin_timer_out) begin
      pin_out  = timer_out;
      pin_oe_n = 1'b0;
    end else if (func == pin_gpio && !dir_in) begin
      pin_oe_n = 1'b0;
    end
  end

  // no open-drain mode exists on this port, so the pull-high only
  // survives on a digital input
  assign pullup_on   = pu_en && gpio_input;
  assign pulldown_on = pd_en && gpio_input;
  assign analog_sel  = (func == pin_analog);
  assign amp_sel     = (func == pin_amp_out);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= pin_in;
    end
  end

  // falling edge only counts while idle or asleep on a gpio input
  assign wake = wu_en && gpio_input && low_power && pin_prev && !pin_in;

endmodule // port_pin_cell
`default_nettype wire

/* File: tb/pad_model.sv */
// pad_model: the pins as the outside world sees them
// assumes the bench says which pins it drives and to what level
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] pulldown_on,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] level
);
  logic [7:0] last;
  always_ff @(posedge clk) last <= level;
  // a floating pin flips each cycle so no stale level reads as good
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) level[i] = pin_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pullup_on[i]) level[i] = 1'b1;
      else if (pulldown_on[i]) level[i] = 1'b0;
      else level[i] = ~last[i];
    end
  end
endmodule // pad_model
`default_nettype wire

/* File: tb/port_a_gpio_with_wakeup_tb.sv */
// port_a_gpio_with_wakeup_tb: directed checks of the port
// assumes the pad model resolves pin levels from both sides
`timescale 1ns/1ps
`default_nettype none
module port_a_gpio_with_wakeup_tb;
  import port_a_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              low_power = 1'b0;
  logic              timer_pwm_output = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [7:0]        reg_wdata = 8'h00;
  logic [7:0]        ext_val = 8'hff;
  logic [7:0]        ext_en = 8'hff;
  logic [7:0]        reg_rdata, pin_in, pin_out, pin_oe_n;
  logic [7:0]        pullup_on, pulldown_on;
  logic              analog_input_zero, analog_input_one;
  logic              amplifier_one_output, wake_request;
  logic              timer_snapshot_input, timer_clock_input;
  int                miscompares = 0;
  int                comparisons = 0;
  always #5 clk = ~clk;
  port_a_gpio_with_wakeup DUT (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .low_power, .timer_pwm_output, .pin_in,
    .pin_out, .pin_oe_n, .pullup_on, .pulldown_on, .analog_input_zero,
    .analog_input_one, .amplifier_one_output, .timer_snapshot_input,
    .timer_clock_input, .wake_request);
  pad_model pads (.clk, .pin_out, .pin_oe_n, .pullup_on, .pulldown_on,
    .ext_val, .ext_en, .level(pin_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic t_reset;
    chk(pin_oe_n & PORT_MASK, PORT_MASK);
    rd(ADDR_DIRECTION, RST_DIRECTION);
    for (int a = 2; a < 6; a++) rd(3'(a), RST_ZERO);
  endtask
  task automatic t_regs;
    for (int a = 2; a < 8; a++) begin
      wr(3'(a), 8'hff);
      rd(3'(a), a == 5 ? FUNC_SEL_MASK : a > 5 ? 8'h00 : PORT_MASK);
      wr(3'(a), 8'h00);
    end
  endtask
  task automatic t_io;
    @(posedge clk) ext_val <= 8'h42;
    wr(ADDR_DIRECTION, 8'h00);
    chk(pin_oe_n & PORT_MASK, 8'h00);
    chk(pin_out & PORT_MASK, RST_DATA_LATCH);
    wr(ADDR_DATA_LATCH, 8'h21);
    rd(ADDR_DATA_LATCH, 8'h21);
    wr(ADDR_DIRECTION, PORT_MASK);
    rd(ADDR_DATA_LATCH, 8'h42);
    // peripheral inputs follow the pad level in either direction, checked here as inputs
    chk({6'h0, timer_clock_input, timer_snapshot_input}, 8'h01);
    wr(ADDR_DIRECTION, 8'he6);
    rd(ADDR_DATA_LATCH, 8'h43);
    // bit set by read-modify-write copies input levels into the latch
    wr(ADDR_DATA_LATCH, 8'h43 | 8'h04);
    wr(ADDR_DIRECTION, 8'h00);
    chk(pin_out & PORT_MASK, 8'h47);
    wr(ADDR_DIRECTION, PORT_MASK);
  endtask
  task automatic t_pull;
    wr(ADDR_PULLUP, 8'hff);
    chk(pullup_on & PORT_MASK, PORT_MASK);
    wr(ADDR_DIRECTION, 8'he6);
    wr(ADDR_FUNC_SEL, 8'h40);
    chk(pullup_on & PORT_MASK, 8'ha6);
    chk({7'h0, analog_input_zero}, 8'h01);
    wr(ADDR_PULLUP, 8'h00);
    wr(ADDR_PULLDOWN, 8'hff);
    chk(pulldown_on & PORT_MASK, 8'ha6);
    wr(ADDR_PULLDOWN, 8'h00);
    wr(ADDR_FUNC_SEL, 8'he2);
    chk({6'h0, analog_input_one, amplifier_one_output}, 8'h03);
    wr(ADDR_FUNC_SEL, 8'h20);
    wr(ADDR_DIRECTION, 8'h00);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk) timer_pwm_output <= 1'(v);
      #1 chk({7'h0, pin_out[5]}, 8'(v));
    end
    wr(ADDR_FUNC_SEL, 8'h00);
    wr(ADDR_DIRECTION, PORT_MASK);
  endtask
  task automatic fall(input logic [7:0] v, input logic exp);
    @(posedge clk) ext_val <= 8'hff;
    @(posedge clk) ext_val <= v;
    #1 chk({7'h0, wake_request}, {7'h0, exp});
  endtask
  task automatic t_wake;
    wr(ADDR_WAKEUP, 8'h04);
    @(posedge clk) low_power <= 1'b1;
    fall(8'hfb, 1'b1);
    @(posedge clk) #1 chk({7'h0, wake_request}, 8'h00);
    fall(8'hfe, 1'b0);
    // a pin routed away from gpio must not wake the core
    wr(ADDR_WAKEUP, 8'h02);
    wr(ADDR_FUNC_SEL, 8'h02);
    fall(8'hfd, 1'b0);
    wr(ADDR_FUNC_SEL, 8'h00);
    // an output pin falling under its own latch must not wake either
    wr(ADDR_DIRECTION, 8'he5);
    wr(ADDR_DATA_LATCH, 8'h45);
    chk({7'h0, wake_request}, 8'h00);
    wr(ADDR_DIRECTION, PORT_MASK);
    wr(ADDR_WAKEUP, 8'h04);
    @(posedge clk) low_power <= 1'b0;
    fall(8'hfb, 1'b0);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_io;
    t_pull;
    t_wake;
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_sim;
  end
endmodule // port_a_gpio_with_wakeup_tb
`default_nettype wire

/* File: tb/port_a_props.sv */
// port_a_props: checks on the port's register reads, pulls and wake pulse
// assumes it is bound to the port top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module port_a_props
  import port_a_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              low_power,
  input wire logic [7:0]        pin_in,
  input wire logic [7:0]        pin_oe_n,
  input wire logic [7:0]        pullup_on,
  input wire logic [7:0]        pulldown_on,
  input wire logic              wake_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  unmapped_read_a: assert property (reg_rd && reg_addr > 3'h5 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  fsel_zero_a: assert property (reg_rd && reg_addr == ADDR_FUNC_SEL |=>
    (reg_rdata & ~FUNC_SEL_MASK) == 8'h00) else $error("select bits leak");
  dir_drive_a: assert property (reg_wr && reg_addr == ADDR_DIRECTION &&
    !reg_wdata[0] |=> !pin_oe_n[0]) else $error("pin 0 not driven");
  pullup_gate_a: assert property ((pullup_on & ~pin_oe_n) == 8'h00)
    else $error("pull-high on driven pin");
  pulldown_gate_a: assert property ((pulldown_on & ~pin_oe_n) == 8'h00)
    else $error("pull-low on driven pin");
  pullup_off_a: assert property (reg_wr && reg_addr == ADDR_PULLUP &&
    reg_wdata == 8'h00 |=> pullup_on == 8'h00) else $error("pull-high on");
  pulldown_off_a: assert property (reg_wr && reg_addr == ADDR_PULLDOWN &&
    reg_wdata == 8'h00 |=> pulldown_on == 8'h00) else $error("pull-low on");
  wake_sleep_a: assert property (wake_request |-> low_power)
    else $error("wake while running");
  wake_edge_a: assert property (wake_request |->
    (~pin_in & $past(pin_in) & PORT_MASK) != 8'h00) else $error("no fall");
  wake_off_a: assert property (reg_wr && reg_addr == ADDR_WAKEUP &&
    reg_wdata == 8'h00 |=> !wake_request) else $error("wake disabled");
  cover property (wake_request);
  cover property (reg_rd && reg_addr > 3'h5);
  cover property (pullup_on != 8'h00 && pin_oe_n[0] == 1'b0);
endmodule // port_a_props
bind port_a_gpio_with_wakeup port_a_props props (.clk, .rst_n, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .low_power, .pin_in, .pin_oe_n,
  .pullup_on, .pulldown_on, .wake_request);
`default_nettype wire
